// File: rtl/asmap_top.v
`include "asmap_defines.vh"
`default_nettype none
// Contract
// - bank c group 0: compare, shift data, control at 0..2; rest reserved
// - bank 0 group 0: ports 0..3 at 0..3, general registers 4..15; the code has no ports and keeps 0..3 as general registers
// - bank f group 0: port config 0, stop recovery 11, watchdog 15
// - first twelve program bytes hold six interrupt vectors; rom follows
// - with ports 0/1, fetch beyond rom becomes external memory cycle
// - without ports 0/1, fetch beyond rom runs nops, wraps to zero
// - read protect blocks program-memory and external loads from program memory
// - low address muxed with data on port 1, high byte port 0
// - external cycles framed by address strobe, data strobe, read/write
// - external program memory spans from rom end plus one to ffff
// - external data memory addressable from 4096 up to 60 kbytes
// - data memory select inactive for program loads, low for data loads when port 3 mode bits 3 and 4 are both set
// - port 0-1 mode bit picks internal or external stack
// - stack pointer high byte at fe, low byte at ff
// - decrement before push, increment after pop
// - call pushes program counter, return pops it; with external stack the code writes nothing and pops from internal registers
// - interrupt pushes counter and flags, interrupt return restores both; with external stack the code writes nothing and pops internal registers
// - internal stack uses low byte only; high byte is ordinary register
// - pointer low nibble selects bank, only for addresses 00..0f
module asmap_top #(
    parameter ROM_TOP = 16'h0fff,
    parameter HAS_P01 = 1
) (
    // clock and reset
    input wire I_CLK,
    input wire I_NRST,
    // register file port
    input wire [7:0] I_REG_ADDR,
    input wire [7:0] I_REG_WDATA,
    input wire I_REG_WR,
    input wire [7:0] I_RP,
    output reg [7:0] O_REG_RDATA,
    // configuration
    input wire I_ROM_PROTECT,
    input wire [7:0] I_PORT3_MODE,
    // memory request
    input wire I_MEM_REQ,
    input wire [1:0] I_MEM_KIND,
    input wire [15:0] I_MEM_ADDR,
    output wire O_MEM_BUSY,
    output reg O_MEM_DONE,
    output reg O_MEM_BLOCKED,
    output reg O_MEM_NOP,
    output reg [7:0] O_MEM_RDATA,
    output reg [15:0] O_PC_WRAP,
    // stack operation
    input wire [2:0] I_STK_OP,
    input wire [15:0] I_STK_PC,
    input wire [7:0] I_STK_FLAGS,
    output reg [15:0] O_STK_PC,
    output reg [7:0] O_STK_FLAGS,
    output wire [15:0] O_STACK_POINTER,
    // external memory pins
    input wire [7:0] I_P1_IN,
    output reg [7:0] O_P1_OUT,
    output reg O_P1_OE,
    output reg [7:0] O_P0_OUT,
    output reg O_ADDRESS_STROBE_N,
    output reg O_DATA_STROBE_N,
    output reg O_READ_WRITE,
    output reg O_DATA_MEMORY_SELECT_N
);
    reg rst_a_r, rst_b_r;
    wire rst_n = rst_b_r;
    always @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_a_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_b_r <= rst_a_r;
        end
    end
    reg [7:0] p1_s1_r, p1_s2_r;
    always @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            p1_s1_r <= 8'h00;
            p1_s2_r <= 8'h00;
        end else begin
            p1_s1_r <= I_P1_IN;
            p1_s2_r <= p1_s1_r;
        end
    end
    reg [7:0] gpr_r [0:255];
    reg [7:0] spi_cmp_r, spi_dat_r, spi_ctl_r, pcfg_r, stop_r, wdog_r;
    reg [7:0] port_zero_one_mode_r, sph_r, spl_r;
    wire [3:0] bank = I_RP[3:0];
    wire low_rng = (I_REG_ADDR[7:4] == 4'h0);
    wire in_spi = low_rng && (bank == `ASMAP_BANK_SPI);
    wire in_ctl = low_rng && (bank == `ASMAP_BANK_CTL);
    wire in_std = !low_rng || (bank == `ASMAP_BANK_STD);
    wire [3:0] pos = I_REG_ADDR[3:0];
    wire ext_stk = port_zero_one_mode_r[`ASMAP_PORT_ZERO_ONE_MODE_STK_BIT];
    wire [15:0] sp = ext_stk ? {sph_r, spl_r} : {8'h00, spl_r};
    assign O_STACK_POINTER = sp;
    // read mux
    always @* begin
        O_REG_RDATA = `ASMAP_RSVD_READ;
        if (in_spi) begin
            case (pos)
                `ASMAP_POS_SCMP: O_REG_RDATA = spi_cmp_r;
                `ASMAP_POS_SDAT: O_REG_RDATA = spi_dat_r;
                `ASMAP_POS_SCTL: O_REG_RDATA = spi_ctl_r;
                default: O_REG_RDATA = `ASMAP_RSVD_READ;
            endcase
        end else if (in_ctl) begin
            case (pos)
                `ASMAP_POS_PCFG: O_REG_RDATA = pcfg_r;
                `ASMAP_POS_STOP: O_REG_RDATA = stop_r;
                `ASMAP_POS_WDOG: O_REG_RDATA = wdog_r;
                default: O_REG_RDATA = `ASMAP_RSVD_READ;
            endcase
        end else if (in_std) begin
            case (I_REG_ADDR)
                `ASMAP_ADR_PORT_ZERO_ONE_MODE: O_REG_RDATA = port_zero_one_mode_r;
                `ASMAP_ADR_SPH: O_REG_RDATA = sph_r;
                `ASMAP_ADR_SPL: O_REG_RDATA = spl_r;
                default: O_REG_RDATA = gpr_r[I_REG_ADDR];
            endcase
        end
    end
    // stack engine states
    localparam ST_IDLE = 3'b001;
    localparam ST_PUSH2 = 3'b010;
    localparam ST_POP2 = 3'b100;
    reg [2:0] st_r;
    reg [2:0] op_r;
    reg [7:0] hold_r;
    // mem port and ext cycle engine
    localparam MS_IDLE = 5'b00001;
    localparam MS_ADDR = 5'b00010;
    localparam MS_DATA = 5'b00100;
    localparam MS_HOLD = 5'b01000;
    localparam MS_END = 5'b10000;
    reg [4:0] ms_r;
    reg [1:0] kind_r;
    reg [15:0] nop_pc_r;
    assign O_MEM_BUSY = (ms_r != MS_IDLE);
    wire stk_wr_int = !ext_stk;
    function [15:0] dec1;
        input [15:0] v;
        dec1 = v - 16'h0001;
    endfunction
    function [15:0] inc1;
        input [15:0] v;
        inc1 = v + 16'h0001;
    endfunction
    // register writes and stack engine
    integer k;
    always @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            spi_cmp_r <= 8'h00;
            spi_dat_r <= 8'h00;
            spi_ctl_r <= 8'h00;
            pcfg_r <= 8'h00;
            stop_r <= 8'h00;
            wdog_r <= 8'h00;
            port_zero_one_mode_r <= 8'h00;
            sph_r <= 8'h00;
            spl_r <= 8'h00;
            st_r <= ST_IDLE;
            op_r <= `ASMAP_OP_NONE;
            hold_r <= 8'h00;
            O_STK_PC <= 16'h0000;
            O_STK_FLAGS <= 8'h00;
            for (k = 0; k < 256; k = k + 1) gpr_r[k] <= 8'h00;
        end else begin
            if (I_REG_WR) begin
                if (in_spi) begin
                    if (pos == `ASMAP_POS_SCMP) spi_cmp_r <= I_REG_WDATA;
                    if (pos == `ASMAP_POS_SDAT) spi_dat_r <= I_REG_WDATA;
                    if (pos == `ASMAP_POS_SCTL) spi_ctl_r <= I_REG_WDATA;
                end else if (in_ctl) begin
                    if (pos == `ASMAP_POS_PCFG) pcfg_r <= I_REG_WDATA;
                    if (pos == `ASMAP_POS_STOP) stop_r <= I_REG_WDATA;
                    if (pos == `ASMAP_POS_WDOG) wdog_r <= I_REG_WDATA;
                end else if (I_REG_ADDR == `ASMAP_ADR_PORT_ZERO_ONE_MODE) begin
                    port_zero_one_mode_r <= I_REG_WDATA;
                end else if (I_REG_ADDR == `ASMAP_ADR_SPH) begin
                    sph_r <= I_REG_WDATA;
                end else if (I_REG_ADDR == `ASMAP_ADR_SPL) begin
                    spl_r <= I_REG_WDATA;
                end else begin
                    gpr_r[I_REG_ADDR] <= I_REG_WDATA;
                end
            end
            case (st_r)
                ST_IDLE: begin
                    op_r <= I_STK_OP;
                    case (I_STK_OP)
                        `ASMAP_OP_PUSH, `ASMAP_OP_CALL, `ASMAP_OP_INT: begin
                            {sph_r, spl_r} <= ext_stk ? dec1(sp) : {sph_r, spl_r - 8'h01};
                            if (stk_wr_int) gpr_r[spl_r - 8'h01] <=
                                (I_STK_OP == `ASMAP_OP_PUSH) ? I_STK_FLAGS : I_STK_PC[7:0];
                            hold_r <= I_STK_PC[15:8];
                            if (I_STK_OP != `ASMAP_OP_PUSH) st_r <= ST_PUSH2;
                        end
                        `ASMAP_OP_POP, `ASMAP_OP_RET, `ASMAP_OP_INTERRUPT_RETURN_OP: begin
                            {sph_r, spl_r} <= ext_stk ? inc1(sp) : {sph_r, spl_r + 8'h01};
                            hold_r <= gpr_r[spl_r];
                            if (I_STK_OP == `ASMAP_OP_POP) O_STK_FLAGS <= gpr_r[spl_r];
                            else st_r <= ST_POP2;
                        end
                        default: st_r <= ST_IDLE;
                    endcase
                end
                ST_PUSH2: begin
                    {sph_r, spl_r} <= ext_stk ? dec1(sp) : {sph_r, spl_r - 8'h01};
                    if (stk_wr_int) gpr_r[spl_r - 8'h01] <= hold_r;
                    if (op_r == `ASMAP_OP_INT) begin
                        op_r <= `ASMAP_OP_PUSH;
                        hold_r <= I_STK_FLAGS;
                    end else st_r <= ST_IDLE;
                end
                ST_POP2: begin
                    {sph_r, spl_r} <= ext_stk ? inc1(sp) : {sph_r, spl_r + 8'h01};
                    if (op_r == `ASMAP_OP_INTERRUPT_RETURN_OP) begin
                        O_STK_FLAGS <= hold_r;
                        hold_r <= gpr_r[spl_r];
                        op_r <= `ASMAP_OP_RET;
                    end else begin
                        O_STK_PC <= {hold_r, gpr_r[spl_r]};
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    // external memory engine
    // vectors below rom code
    wire beyond_rom = (I_MEM_ADDR > ROM_TOP);
    wire blocked = I_ROM_PROTECT && (I_MEM_KIND != `ASMAP_MK_FETCH)
        && !(I_MEM_KIND == `ASMAP_MK_DATA && I_MEM_ADDR >= `ASMAP_DATA_BASE);
    // select enabled by port 3 mode
    wire dm_en = I_PORT3_MODE[`ASMAP_P3M_DM_LO] && I_PORT3_MODE[`ASMAP_P3M_DM_HI];
    reg [15:0] addr_r;
    always @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ms_r <= MS_IDLE;
            kind_r <= `ASMAP_MK_FETCH;
            addr_r <= 16'h0000;
            nop_pc_r <= 16'h0000;
            O_MEM_DONE <= 1'b0;
            O_MEM_BLOCKED <= 1'b0;
            O_MEM_NOP <= 1'b0;
            O_MEM_RDATA <= 8'h00;
            O_PC_WRAP <= 16'h0000;
            O_P1_OUT <= 8'h00;
            O_P1_OE <= 1'b0;
            O_P0_OUT <= 8'h00;
            O_ADDRESS_STROBE_N <= 1'b1;
            O_DATA_STROBE_N <= 1'b1;
            O_READ_WRITE <= 1'b1;
            O_DATA_MEMORY_SELECT_N <= 1'b1;
        end else begin
            O_MEM_DONE <= 1'b0;
            O_MEM_BLOCKED <= 1'b0;
            O_MEM_NOP <= 1'b0;
            case (ms_r)
                MS_IDLE: begin
                    if (I_MEM_REQ) begin
                        if (blocked) begin
                            O_MEM_BLOCKED <= 1'b1;
                            O_MEM_DONE <= 1'b1;
                        end else if (HAS_P01 == 0 && beyond_rom) begin
                            O_MEM_NOP <= 1'b1;
                            O_MEM_DONE <= 1'b1;
                            nop_pc_r <= I_MEM_ADDR;
                            O_PC_WRAP <= (I_MEM_ADDR == `ASMAP_PC_TOP) ? 16'h0000
                                : inc1(I_MEM_ADDR);
                        end else if (beyond_rom || I_MEM_KIND == `ASMAP_MK_DATA) begin
                            ms_r <= MS_ADDR;
                            kind_r <= I_MEM_KIND;
                            addr_r <= I_MEM_ADDR;
                            O_P1_OUT <= I_MEM_ADDR[7:0];
                            O_P0_OUT <= I_MEM_ADDR[15:8];
                            O_P1_OE <= 1'b1;
                            O_READ_WRITE <= 1'b1;
                            O_DATA_MEMORY_SELECT_N <= !(dm_en && I_MEM_KIND == `ASMAP_MK_DATA);
                            O_ADDRESS_STROBE_N <= 1'b0;
                        end else begin
                            O_MEM_DONE <= 1'b1;
                        end
                    end
                end
                MS_ADDR: begin
                    O_ADDRESS_STROBE_N <= 1'b1;
                    O_P1_OE <= 1'b0;
                    O_DATA_STROBE_N <= 1'b0;
                    ms_r <= MS_DATA;
                end
                MS_DATA: begin
                    ms_r <= MS_HOLD;
                end
                // data still crossing the pin synchroniser
                MS_HOLD: begin
                    ms_r <= MS_END;
                end
                MS_END: begin
                    O_MEM_RDATA <= p1_s2_r;
                    O_DATA_STROBE_N <= 1'b1;
                    O_DATA_MEMORY_SELECT_N <= 1'b1;
                    O_MEM_DONE <= 1'b1;
                    ms_r <= MS_IDLE;
                end
                default: ms_r <= MS_IDLE;
            endcase
        end
    end
endmodule // asmap_top
`default_nettype wire

// File: rtl/asmap_defines.vh
`ifndef ASMAP_DEFINES_VH
`define ASMAP_DEFINES_VH
// register file addresses
`define ASMAP_BANK_STD 4'h0
`define ASMAP_BANK_SPI 4'hc
`define ASMAP_BANK_CTL 4'hf
`define ASMAP_POS_SCMP 4'h0
`define ASMAP_POS_SDAT 4'h1
`define ASMAP_POS_SCTL 4'h2
`define ASMAP_POS_PCFG 4'h0
`define ASMAP_POS_STOP 4'hb
`define ASMAP_POS_WDOG 4'hf
`define ASMAP_ADR_PORT_ZERO_ONE_MODE 8'hf8
`define ASMAP_ADR_SPH 8'hfe
`define ASMAP_ADR_SPL 8'hff
`define ASMAP_ADR_PORTS_TOP 8'h03
`define ASMAP_RSVD_READ 8'hff
// mode register fields
`define ASMAP_PORT_ZERO_ONE_MODE_STK_BIT 2
`define ASMAP_P3M_DM_LO 3
`define ASMAP_P3M_DM_HI 4
// program memory
`define ASMAP_VEC_BYTES 16'h000c
`define ASMAP_PC_TOP 16'hffff
`define ASMAP_DATA_BASE 16'h1000
// stack operation codes
`define ASMAP_OP_NONE 3'h0
`define ASMAP_OP_PUSH 3'h1
`define ASMAP_OP_POP 3'h2
`define ASMAP_OP_CALL 3'h3
`define ASMAP_OP_RET 3'h4
`define ASMAP_OP_INT 3'h5
`define ASMAP_OP_INTERRUPT_RETURN_OP 3'h6
// memory access kinds
`define ASMAP_MK_FETCH 2'h0
`define ASMAP_MK_PROG 2'h1
`define ASMAP_MK_DATA 2'h2
`endif

// File: tb/asmap_sva.sv
`include "asmap_defines.vh"
`default_nettype none
module asmap_sva #(
    parameter ROM_TOP = 16'h0fff,
    parameter HAS_P01 = 1
) (
    input wire I_CLK, input wire I_NRST, input wire [7:0] I_REG_ADDR, input wire [7:0] I_RP,
    input wire [7:0] O_REG_RDATA, input wire I_ROM_PROTECT, input wire [7:0] I_PORT3_MODE,
    input wire I_MEM_REQ, input wire [1:0] I_MEM_KIND, input wire [15:0] I_MEM_ADDR,
    input wire O_MEM_BUSY, input wire O_MEM_DONE, input wire O_MEM_BLOCKED, input wire O_P1_OE,
    input wire [7:0] O_P1_OUT, input wire [7:0] O_P0_OUT, input wire O_ADDRESS_STROBE_N,
    input wire O_DATA_STROBE_N, input wire O_DATA_MEMORY_SELECT_N
);
    timeunit 1ns;
    timeprecision 1ns;
    wire take = I_MEM_REQ && !O_MEM_BUSY;
    reg [15:0] cap_addr_r;
    reg [1:0] cap_kind_r;
    // request capture
    always @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cap_addr_r <= 16'h0000;
            cap_kind_r <= 2'h0;
        end else if (take) begin
            cap_addr_r <= I_MEM_ADDR;
            cap_kind_r <= I_MEM_KIND;
        end
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);
    a_as_to_ds: assert property ($fell(O_ADDRESS_STROBE_N) |=>
        $rose(O_ADDRESS_STROBE_N) && $fell(O_DATA_STROBE_N) && !O_P1_OE)
        else $error("data strobe does not follow address strobe");
    a_ds_frame: assert property ($fell(O_DATA_STROBE_N) |=>
        !O_DATA_STROBE_N [*2] ##1 (O_DATA_STROBE_N && O_MEM_DONE))
        else $error("data strobe frame wrong");
    a_addr_drive: assert property ($fell(O_ADDRESS_STROBE_N) |-> O_P1_OE &&
        O_P1_OUT == cap_addr_r[7:0] && O_P0_OUT == cap_addr_r[15:8])
        else $error("address bytes wrong at strobe");
    a_dm_prog: assert property ($fell(O_ADDRESS_STROBE_N) &&
        cap_kind_r == `ASMAP_MK_PROG |-> O_DATA_MEMORY_SELECT_N)
        else $error("data select active on program load");
    a_dm_data: assert property ($fell(O_ADDRESS_STROBE_N) && cap_kind_r == `ASMAP_MK_DATA &&
        I_PORT3_MODE[4:3] == 2'b11 |-> !O_DATA_MEMORY_SELECT_N)
        else $error("data select idle on data load");
    a_fetch_ext: assert property (take && I_MEM_KIND == `ASMAP_MK_FETCH &&
        I_MEM_ADDR > ROM_TOP && HAS_P01 != 0 |-> ##[1:2] $fell(O_ADDRESS_STROBE_N))
        else $error("no external cycle for fetch beyond rom");
    a_rom_inside: assert property (take && I_MEM_KIND == `ASMAP_MK_FETCH &&
        I_MEM_ADDR <= ROM_TOP |-> O_ADDRESS_STROBE_N throughout ##[1:2] O_MEM_DONE)
        else $error("internal fetch went outside");
    a_protect_blk: assert property (take && I_MEM_KIND == `ASMAP_MK_PROG &&
        I_ROM_PROTECT && I_MEM_ADDR <= ROM_TOP |-> ##[1:2] O_MEM_BLOCKED)
        else $error("protected program read not blocked");
    a_reserved_rd: assert property (I_RP[3:0] == 4'hc && I_REG_ADDR >= 8'h03 &&
        I_REG_ADDR <= 8'h0f |-> O_REG_RDATA == `ASMAP_RSVD_READ)
        else $error("reserved position read wrong");
endmodule // asmap_sva
bind asmap_top asmap_sva #(.ROM_TOP(ROM_TOP), .HAS_P01(HAS_P01)) u_sva (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_REG_ADDR(I_REG_ADDR), .I_RP(I_RP),
    .O_REG_RDATA(O_REG_RDATA), .I_ROM_PROTECT(I_ROM_PROTECT), .I_PORT3_MODE(I_PORT3_MODE),
    .I_MEM_REQ(I_MEM_REQ), .I_MEM_KIND(I_MEM_KIND), .I_MEM_ADDR(I_MEM_ADDR),
    .O_MEM_BUSY(O_MEM_BUSY), .O_MEM_DONE(O_MEM_DONE), .O_MEM_BLOCKED(O_MEM_BLOCKED),
    .O_P1_OE(O_P1_OE), .O_P1_OUT(O_P1_OUT), .O_P0_OUT(O_P0_OUT),
    .O_ADDRESS_STROBE_N(O_ADDRESS_STROBE_N), .O_DATA_STROBE_N(O_DATA_STROBE_N),
    .O_DATA_MEMORY_SELECT_N(O_DATA_MEMORY_SELECT_N));
`default_nettype wire

// File: tb/asmap_xmem.sv
`default_nettype none
module asmap_xmem (
    input wire logic i_clk,
    input wire logic i_as_n, i_ds_n, i_rw, i_dm_n, i_oe,
    input wire logic [7:0] i_hi, i_lo,
    output logic [7:0] o_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] addr_r;
    logic dm_r;
    logic [7:0] last_r = 8'h00;
    always @(posedge i_clk) begin
        if (!i_as_n) begin
            addr_r <= {i_hi, i_lo};
            dm_r <= i_dm_n;
        end
        last_r <= o_bus;
    end
    // answer only in a read data strobe
    always_comb begin
        if (i_oe) o_bus = i_lo;
        else if (!i_ds_n && i_rw) o_bus = addr_r[7:0] ^ addr_r[15:8] ^ (dm_r ? 8'h00 : 8'ha5);
        else o_bus = ~last_r;
    end
endmodule // asmap_xmem
`default_nettype wire

// File: tb/testbench.sv
`include "asmap_defines.vh"
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, prot = 1'b0, req = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rp = 8'h00, p3m = 8'h18, flags = 8'h00;
    logic [1:0] kind = 2'h0;
    logic [15:0] maddr = 16'h0000, pc = 16'h0000;
    logic [2:0] op = 3'h0;
    wire [7:0] rdata, mrdata, stk_flags, p1_out, p0_out, p1_in;
    wire busy, done, blk, nop, oe, as_n, ds_n, rw, dm_n;
    wire [15:0] stk_pc, sp;
    int miscompares = 0, n_compared = 0;
    asmap_top dut (
        .I_CLK(clk), .I_NRST(nrst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
        .I_RP(rp), .O_REG_RDATA(rdata), .I_ROM_PROTECT(prot), .I_PORT3_MODE(p3m),
        .I_MEM_REQ(req), .I_MEM_KIND(kind), .I_MEM_ADDR(maddr), .O_MEM_BUSY(busy),
        .O_MEM_DONE(done), .O_MEM_BLOCKED(blk), .O_MEM_NOP(nop), .O_MEM_RDATA(mrdata),
        .O_PC_WRAP(), .I_STK_OP(op), .I_STK_PC(pc), .I_STK_FLAGS(flags), .O_STK_PC(stk_pc),
        .O_STK_FLAGS(stk_flags), .O_STACK_POINTER(sp), .I_P1_IN(p1_in), .O_P1_OUT(p1_out),
        .O_P1_OE(oe), .O_P0_OUT(p0_out), .O_ADDRESS_STROBE_N(as_n), .O_DATA_STROBE_N(ds_n),
        .O_READ_WRITE(rw), .O_DATA_MEMORY_SELECT_N(dm_n));
    asmap_xmem xmem (.i_clk(clk), .i_as_n(as_n), .i_ds_n(ds_n), .i_rw(rw), .i_dm_n(dm_n),
        .i_oe(oe), .i_hi(p0_out), .i_lo(p1_out), .o_bus(p1_in));
    wire np_nop, np_done;
    wire [15:0] np_wrap;
    // variant without ports 0 and 1
    asmap_top #(.HAS_P01(0)) dut_np (
        .I_CLK(clk), .I_NRST(nrst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WR(wr),
        .I_RP(rp), .O_REG_RDATA(), .I_ROM_PROTECT(prot), .I_PORT3_MODE(p3m),
        .I_MEM_REQ(req), .I_MEM_KIND(kind), .I_MEM_ADDR(maddr), .O_MEM_BUSY(),
        .O_MEM_DONE(np_done), .O_MEM_BLOCKED(), .O_MEM_NOP(np_nop), .O_MEM_RDATA(),
        .O_PC_WRAP(np_wrap), .I_STK_OP(op), .I_STK_PC(pc), .I_STK_FLAGS(flags), .O_STK_PC(),
        .O_STK_FLAGS(), .O_STACK_POINTER(), .I_P1_IN(8'h00), .O_P1_OUT(),
        .O_P1_OE(), .O_P0_OUT(), .O_ADDRESS_STROBE_N(), .O_DATA_STROBE_N(),
        .O_READ_WRITE(), .O_DATA_MEMORY_SELECT_N());
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic close_out;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick;
        @(posedge clk);
        #5;
    endtask
    task automatic rd(input [7:0] r, input [7:0] a, input [7:0] e);
        rp = r;
        addr = a;
        #20;
        `CHK(rdata, e)
        tick();
    endtask
    task automatic wr_rd(input [7:0] r, input [7:0] a, input [7:0] d, input [7:0] e);
        rp = r;
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick();
        wr = 1'b0;
        rd(r, a, e);
    endtask
    task automatic mem_case(input [1:0] k, input [15:0] a, input p, input [7:0] m,
        input [3:0] est, input [7:0] ed);
        logic [3:0] st;
        st = 4'h0;
        prot = p;
        p3m = m;
        kind = k;
        maddr = a;
        req = 1'b1;
        tick();
        req = 1'b0;
        for (int i = 0; i < 10 && !st[0]; i++) begin
            st = st | {!as_n, !dm_n, blk, done | blk | nop};
            if (!st[0]) tick();
        end
        `CHK(st, est)
        `CHK(rw, 1'b1)
        if (est[3]) `CHK(mrdata, ed)
        tick();
    endtask
    task automatic stk(input [2:0] o, input [15:0] p, input [7:0] f);
        op = o;
        pc = p;
        flags = f;
        tick();
        op = 3'h0;
        repeat (3) tick();
    endtask
    task automatic nop_case(input [15:0] a, input [15:0] w);
        kind = `ASMAP_MK_FETCH;
        maddr = a;
        req = 1'b1;
        tick();
        req = 1'b0;
        `CHK({np_nop, np_done, np_wrap}, {2'b11, w})
        repeat (6) tick();
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk);
        #5;
        nrst = 1'b1;
        repeat (3) tick();
        for (int i = 0; i < 16; i++) wr_rd(8'h00, i[7:0], 8'h40 + i[7:0], 8'h40 + i[7:0]);
        wr_rd(8'h0c, 8'h00, 8'hc0, 8'hc0);
        wr_rd(8'h0c, 8'h01, 8'hc1, 8'hc1);
        wr_rd(8'h0c, 8'h02, 8'hc2, 8'hc2);
        wr_rd(8'h0c, 8'h05, 8'h11, `ASMAP_RSVD_READ);
        wr_rd(8'h0f, 8'h00, 8'hf0, 8'hf0);
        wr_rd(8'h0f, 8'h0b, 8'hfb, 8'hfb);
        wr_rd(8'h0f, 8'h0f, 8'h7f, 8'h7f);
        wr_rd(8'h0f, 8'h01, 8'h22, `ASMAP_RSVD_READ);
        wr_rd(8'h0c, 8'h10, 8'h99, 8'h99);
        rd(8'h00, 8'h00, 8'h40);
        rd(8'h00, 8'h05, 8'h45);
        $display("register map test done");
        mem_case(`ASMAP_MK_FETCH, 16'h000c, 1'b0, 8'h18, 4'b0001, 8'h00);
        mem_case(`ASMAP_MK_FETCH, 16'h1000, 1'b0, 8'h18, 4'b1001, 8'h10);
        mem_case(`ASMAP_MK_FETCH, 16'hffff, 1'b0, 8'h18, 4'b1001, 8'h00);
        mem_case(`ASMAP_MK_PROG, 16'h2000, 1'b0, 8'h18, 4'b1001, 8'h20);
        mem_case(`ASMAP_MK_DATA, 16'h1234, 1'b0, 8'h18, 4'b1101, 8'h83);
        mem_case(`ASMAP_MK_DATA, 16'hfffe, 1'b0, 8'h18, 4'b1101, 8'ha4);
        mem_case(`ASMAP_MK_PROG, 16'h0100, 1'b1, 8'h18, 4'b0011, 8'h00);
        mem_case(`ASMAP_MK_DATA, 16'h1000, 1'b1, 8'h18, 4'b1101, 8'hb5);
        mem_case(`ASMAP_MK_DATA, 16'h3000, 1'b0, 8'h00, 4'b1001, 8'h30);
        nop_case(16'hffff, 16'h0000);
        nop_case(16'h2000, 16'h2001);
        $display("memory test done");
        wr_rd(8'h00, `ASMAP_ADR_PORT_ZERO_ONE_MODE, 8'h00, 8'h00);
        wr_rd(8'h00, `ASMAP_ADR_SPH, 8'h12, 8'h12);
        wr_rd(8'h00, `ASMAP_ADR_SPL, 8'h80, 8'h80);
        `CHK(sp, 16'h0080)
        stk(`ASMAP_OP_PUSH, 16'h0000, 8'h3c);
        `CHK(sp, 16'h007f)
        rd(8'h00, 8'h7f, 8'h3c);
        stk(`ASMAP_OP_POP, 16'h0000, 8'h00);
        `CHK({sp, stk_flags}, 24'h00803c)
        stk(`ASMAP_OP_CALL, 16'habcd, 8'h00);
        rd(8'h00, 8'h7e, 8'hab);
        rd(8'h00, 8'h7f, 8'hcd);
        stk(`ASMAP_OP_RET, 16'h0000, 8'h00);
        `CHK({sp, stk_pc}, 32'h0080abcd)
        stk(`ASMAP_OP_INT, 16'h1234, 8'h5a);
        `CHK(sp, 16'h007d)
        stk(`ASMAP_OP_INTERRUPT_RETURN_OP, 16'h0000, 8'h00);
        `CHK({sp, stk_pc, stk_flags}, 40'h0080_1234_5a)
        rd(8'h00, `ASMAP_ADR_SPH, 8'h12);
        wr_rd(8'h00, `ASMAP_ADR_PORT_ZERO_ONE_MODE, 8'h04, 8'h04);
        `CHK(sp, 16'h1280)
        stk(`ASMAP_OP_PUSH, 16'h0000, 8'h00);
        `CHK(sp, 16'h127f)
        $display("stack test done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
